// >>> pkg/sock_evt_consts.svh
// offsets, field positions and reset values of the socket event block
// What this block does
// - event bits flag change only, not value
// - writing one clears an event bit
// - inject register writes set event bits
// - host bus reset clears all event bits
// - leaving card reset may re-set events
// - bit 3 flags powered state change
// - bits 2,1 flag detect 2,1 changes
// - cardbus card: bit 0 on rise only
// - 16-bit card: bit 0 on both edges
// - event bits 31..4 read zero
// - mask gates interrupt only, not events
// - mask bit 3 enables power interrupt
// - detect mask 11 enables, 00 blocks
// - mask bit 0 enables status interrupt
// - mask bits 31..4 read zero
// - registers sit at base-address in memory
// - power-management register decoded at 0x20
`ifndef SOCK_EVT_CONSTS_SVH
`define SOCK_EVT_CONSTS_SVH
`define OFS_FLAGS    8'h00
`define OFS_ENABLE   8'h04
`define OFS_STATE    8'h08
`define OFS_INJECT   8'h0c
`define OFS_CONTROL  8'h10
`define OFS_RSVD_LO  8'h14
`define OFS_RSVD_HI  8'h1c
`define OFS_PM       8'h20
`define CFG_OFS_BASE 8'h10
`define PAGE_BITS    8
`define EVT_W        4
`define BIT_POWER    3
`define BIT_DET2     2
`define BIT_DET1     1
`define BIT_CSTS     0
`define BIT_CB_CARD  5
`define BIT_16_CARD  4
`define DET_ON       2'h3
`define STATE_FIXED  32'h3000_0000
`define RST_EVT      4'h0
`define RST_WORD     32'h0000_0000
`endif

// >>> pkg/sock_evt_pkg.sv
// types shared by the socket event block
package sock_evt_pkg;
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } cfg_req_s;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [31:0] addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } mem_req_s;

    typedef struct packed {
        logic socket_powered_state;
        logic detect2_state;
        logic detect1_state;
        logic card_status_state;
    } sock_status_s;
endpackage : sock_evt_pkg

// >>> sim/socket_card_model.sv
// card and socket model driving the status lines
module socket_card_model
    import sock_evt_pkg::*;
(
    // status lines toward the bridge
    output sock_status_s o_status,
    output logic         o_cardbus_card,
    output logic         o_16bit_card,
    output logic         o_card_reset
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        o_status       = '0;
        o_cardbus_card = 1'b0;
        o_16bit_card   = 1'b1;
        o_card_reset   = 1'b0;
    end

    // levels only; caller sits on a falling edge so setup is half a cycle
    task automatic set_lines(input logic [3:0] s, input logic cb,
                             input logic rst);
        o_status       = s;
        o_cardbus_card = cb;
        o_16bit_card   = ~cb;
        o_card_reset   = rst;
    endtask : set_lines
endmodule : socket_card_model

// >>> sim/tb_socket_status_event_mask.sv
// self-checking bench for the socket event block
module tb_socket_status_event_mask
    import sock_evt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [31:0] BASE = 32'h8000_1000;
    logic         clk;
    logic         rst_n;
    cfg_req_s     cfg;
    mem_req_s     mem;
    sock_status_s st;
    logic         cb;
    logic         b16;
    logic         crst;
    logic [31:0]  cfg_rd;
    logic [31:0]  mem_rd;
    logic         cfg_ack;
    logic         mem_ack;
    logic         irq;
    int           errors;
    int           comparisons;

    socket_status_event_mask #(.WIN_BITS(12)) dut_u (
        .i_clk_sys(clk), .i_reset_n(rst_n),
        .i_cfg_req(cfg), .o_cfg_rdata(cfg_rd), .o_cfg_ack(cfg_ack),
        .i_mem_req(mem), .o_mem_rdata(mem_rd), .o_mem_ack(mem_ack),
        .i_status(st), .i_cardbus_card(cb), .i_16bit_card(b16),
        .i_card_reset(crst), .o_status_change_interrupt(irq));

    socket_card_model card_u (
        .o_status(st), .o_cardbus_card(cb), .o_16bit_card(b16),
        .o_card_reset(crst));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic wrap_up;
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : wrap_up

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t word %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t flag %b expected %b", $time, got, exp);
        end
    endtask : chk_bit

    // request held over one rising edge, answer read at the next fall
    task automatic mem_acc(input logic wr, input logic [7:0] ofs,
                           input logic [31:0] wd, output logic [31:0] rd);
        @(negedge clk);
        mem = '{1'b1, wr, BASE | {24'h0, ofs}, 4'hf, wd};
        @(negedge clk);
        mem.valid = 1'b0;
        rd = mem_rd;
        chk_bit(mem_ack, 1'b1);
    endtask : mem_acc

    task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
        logic [31:0] r;
        mem_acc(1'b1, ofs, d, r);
    endtask : wr

    task automatic rd(input logic [7:0] ofs, input logic [31:0] exp);
        logic [31:0] r;
        mem_acc(1'b0, ofs, 32'h0, r);
        chk_word(r, exp);
    endtask : rd

    // config access; ack and read data judged at the fall after the take
    task automatic cfg_acc(input logic w, input logic [7:0] a,
                           input logic [31:0] d, input logic ack_exp,
                           input logic [31:0] rd_exp);
        @(negedge clk);
        cfg = '{1'b1, w, a, 4'hf, d};
        @(negedge clk);
        cfg.valid = 1'b0;
        chk_bit(cfg_ack, ack_exp);
        chk_word(cfg_rd, rd_exp);
    endtask : cfg_acc

    // request that must find no socket page behind it
    task automatic mem_miss(input logic [31:0] a);
        @(negedge clk);
        mem = '{1'b1, 1'b0, a, 4'hf, 32'h0};
        @(negedge clk);
        mem.valid = 1'b0;
        chk_bit(mem_ack, 1'b0);
    endtask : mem_miss

    // low window bits written as ones must not stick; old base read back
    task automatic set_base;
        cfg_acc(1'b1, 8'h10, BASE | 32'h0000_0abc, 1'b1, 32'h0);
    endtask : set_base

    task automatic step(input logic [3:0] s, input logic c, input logic r);
        card_u.set_lines(s, c, r);
        @(negedge clk);
    endtask : step

    task automatic t_inject;
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h0);
        wr(8'h0c, 32'hffff_ffff);
        rd(8'h00, 32'h0000_000f);
        chk_bit(irq, 1'b0);
        wr(8'h00, 32'h5);
        rd(8'h00, 32'ha);
        wr(8'h00, 32'h0);
        rd(8'h00, 32'ha);
        wr(8'h00, 32'ha);
        rd(8'h00, 32'h0);
    endtask : t_inject

    task automatic t_detect;
        wr(8'h04, 32'hffff_ffff);
        rd(8'h04, 32'hf);
        wr(8'h04, 32'h6);
        step(4'b0010, 1'b0, 1'b0);
        chk_bit(irq, 1'b1);
        rd(8'h00, 32'h2);
        wr(8'h04, 32'h2);
        chk_bit(irq, 1'b0);
        wr(8'h04, 32'h0);
        step(4'b0110, 1'b0, 1'b0);
        rd(8'h00, 32'h6);
        wr(8'h00, 32'h6);
        step(4'b0100, 1'b0, 1'b0);
        rd(8'h00, 32'h2);
        wr(8'h00, 32'h2);
    endtask : t_detect

    task automatic t_power;
        wr(8'h04, 32'h8);
        step(4'b1100, 1'b0, 1'b0);
        chk_bit(irq, 1'b1);
        rd(8'h00, 32'h8);
        wr(8'h00, 32'h8);
        chk_bit(irq, 1'b0);
        step(4'b0100, 1'b0, 1'b0);
        rd(8'h00, 32'h8);
        wr(8'h00, 32'h8);
    endtask : t_power

    task automatic t_status;
        wr(8'h04, 32'h1);
        step(4'b0100, 1'b1, 1'b0);
        step(4'b0101, 1'b1, 1'b0);
        chk_bit(irq, 1'b1);
        rd(8'h08, 32'h3000_0025);
        wr(8'h00, 32'h1);
        step(4'b0100, 1'b1, 1'b0);
        rd(8'h00, 32'h0);
        step(4'b0101, 1'b0, 1'b0);
        wr(8'h00, 32'h1);
        step(4'b0100, 1'b0, 1'b0);
        rd(8'h00, 32'h1);
        wr(8'h00, 32'h1);
        wr(8'h04, 32'h0);
    endtask : t_status

    task automatic t_card_reset;
        step(4'b0111, 1'b0, 1'b1);
        step(4'b0111, 1'b0, 1'b1);
        wr(8'h00, 32'hf);
        step(4'b0111, 1'b0, 1'b0);
        rd(8'h00, 32'h7);
        rd(8'h08, 32'h3000_0017);
        wr(8'h00, 32'hf);
    endtask : t_card_reset

    task automatic t_regs;
        wr(8'h20, 32'h1234_5678);
        rd(8'h20, 32'h1234_5678);
        wr(8'h14, 32'hffff_ffff);
        wr(8'h1c, 32'hffff_ffff);
        rd(8'h14, 32'h0);
        rd(8'h1c, 32'h0);
        rd(8'h0c, 32'h0);
        wr(8'h10, 32'h8765_4321);
        rd(8'h10, 32'h8765_4321);
        cfg_acc(1'b0, 8'h10, 32'h0, 1'b1, BASE);
        cfg_acc(1'b0, 8'h14, 32'h0, 1'b0, 32'h0);
        mem_miss(BASE | 32'h0000_0100);
        mem_miss(32'h4000_0000);
    endtask : t_regs

    // software leaves flags set, then the host bus resets mid-run
    task automatic t_host_reset;
        wr(8'h04, 32'hf);
        wr(8'h0c, 32'hf);
        chk_bit(irq, 1'b1);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        chk_bit(irq, 1'b0);
        rst_n = 1'b1;
        mem_miss(BASE);
        set_base();
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h0);
    endtask : t_host_reset

    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        wrap_up();
    end

    initial begin
        errors      = 0;
        comparisons = 0;
        rst_n       = 1'b0;
        cfg         = '0;
        mem         = '0;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        set_base();
        t_inject();
        t_detect();
        t_power();
        t_status();
        t_card_reset();
        t_regs();
        t_host_reset();
        wrap_up();
    end
endmodule : tb_socket_status_event_mask

// >>> src/socket_status_event_mask.sv
// socket status-change event, mask and register decode logic
`include "sock_evt_consts.svh"

module socket_status_event_mask
    import sock_evt_pkg::*;
#(
    parameter int WIN_BITS = 12
) (
    // clock and host bus reset
    input  wire logic         i_clk_sys,
    input  wire logic         i_reset_n,
    // configuration space access
    input  wire cfg_req_s     i_cfg_req,
    output logic [31:0]       o_cfg_rdata,
    output logic              o_cfg_ack,
    // host memory access
    input  wire mem_req_s     i_mem_req,
    output logic [31:0]       o_mem_rdata,
    output logic              o_mem_ack,
    // socket status
    input  wire sock_status_s i_status,
    input  wire logic         i_cardbus_card,
    input  wire logic         i_16bit_card,
    input  wire logic         i_card_reset,
    // status-change interrupt
    output logic              o_status_change_interrupt
);

    if (WIN_BITS <= `PAGE_BITS || WIN_BITS > 31) begin : g_win_check
        $error("WIN_BITS out of range");
    end

    localparam logic [31:0] BASE_MASK =
        ~((32'h1 << WIN_BITS) - 32'h1);

    function automatic logic [31:0] merge_be(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  be
    );
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        return (old_v & ~m) | (new_v & m);
    endfunction : merge_be

    function automatic logic [`EVT_W-1:0] eff_enable(
        input logic [`EVT_W-1:0] en
    );
        logic det_on;
        det_on = (en[`BIT_DET2:`BIT_DET1] == `DET_ON);
        // the two reserved detect codes enable nothing
        return {en[`BIT_POWER], det_on, det_on, en[`BIT_CSTS]};
    endfunction : eff_enable

    logic [31:0]        base_q, base_d;
    logic [31:0]        cfg_rdata_q, cfg_rdata_d;
    logic               cfg_ack_q, cfg_ack_d;
    logic [`EVT_W-1:0]  flags_q, flags_d;
    logic [`EVT_W-1:0]  enable_q, enable_d;
    logic [31:0]        control_q, control_d;
    logic [31:0]        pm_q, pm_d;
    logic [31:0]        rdata_q, rdata_d;
    logic               ack_q, ack_d;
    sock_status_s       prev_q, prev_d;
    logic               prev_valid_q, prev_valid_d;
    logic               card_rst_q, card_rst_d;
    logic               hit;
    logic               wr_hit;
    logic               rd_hit;
    logic [7:0]         ofs;
    logic               rsvd_ofs;
    logic [`EVT_W-1:0]  change_w;
    logic [`EVT_W-1:0]  inject_w;
    logic [`EVT_W-1:0]  exit_w;
    logic [`EVT_W-1:0]  set_w;
    logic [`EVT_W-1:0]  clear_w;
    logic [31:0]        state_w;

    // socket window decode against the base register
    always_comb begin
        ofs = i_mem_req.addr[7:0];
        hit = i_mem_req.valid && (base_q != `RST_WORD)
            && ((i_mem_req.addr & BASE_MASK) == base_q)
            && (i_mem_req.addr[WIN_BITS-1:`PAGE_BITS] == '0);
        wr_hit = hit && i_mem_req.write;
        rd_hit = hit && !i_mem_req.write;
        rsvd_ofs = (ofs >= `OFS_RSVD_LO) && (ofs <= `OFS_RSVD_HI);
    end

    // configuration base-address register
    always_comb begin
        base_d = base_q;
        cfg_ack_d = 1'b0;
        cfg_rdata_d = `RST_WORD;
        if (i_cfg_req.valid && i_cfg_req.addr == `CFG_OFS_BASE) begin
            cfg_ack_d = 1'b1;
            cfg_rdata_d = base_q;
            if (i_cfg_req.write) begin
                base_d = merge_be(base_q, i_cfg_req.wdata,
                                  i_cfg_req.be) & BASE_MASK;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            base_q      <= `RST_WORD;
            cfg_rdata_q <= `RST_WORD;
            cfg_ack_q   <= 1'b0;
        end else begin
            base_q      <= base_d;
            cfg_rdata_q <= cfg_rdata_d;
            cfg_ack_q   <= cfg_ack_d;
        end
    end

    // event detection; flags record that a change happened, not the value
    always_comb begin
        prev_d = i_status;
        prev_valid_d = 1'b1;
        card_rst_d = i_card_reset;
        change_w = '0;
        if (prev_valid_q) begin
            change_w[`BIT_POWER] = i_status.socket_powered_state
                ^ prev_q.socket_powered_state;
            change_w[`BIT_DET2] = i_status.detect2_state
                ^ prev_q.detect2_state;
            change_w[`BIT_DET1] = i_status.detect1_state
                ^ prev_q.detect1_state;
            if (i_cardbus_card) begin
                change_w[`BIT_CSTS] = i_status.card_status_state
                    && !prev_q.card_status_state;
            end else begin
                change_w[`BIT_CSTS] = i_status.card_status_state
                    ^ prev_q.card_status_state;
            end
        end
        // status still asserted when card reset ends
        exit_w = '0;
        if (card_rst_q && !i_card_reset) begin
            exit_w[`BIT_CSTS] = i_status.card_status_state;
            exit_w[`BIT_DET2] = i_status.detect2_state;
            exit_w[`BIT_DET1] = i_status.detect1_state;
        end
        inject_w = '0;
        if (wr_hit && ofs == `OFS_INJECT && i_mem_req.be[0]) begin
            inject_w = i_mem_req.wdata[`EVT_W-1:0];
        end
        clear_w = '0;
        if (wr_hit && ofs == `OFS_FLAGS && i_mem_req.be[0]) begin
            clear_w = i_mem_req.wdata[`EVT_W-1:0];
        end
        // mask plays no part here, events set regardless
        set_w = change_w | inject_w | exit_w;
        // a new event beats a clear landing in the same cycle
        flags_d = (flags_q & ~clear_w) | set_w;
    end

    // register writes and read data
    always_comb begin
        state_w = `STATE_FIXED;
        state_w[`BIT_CB_CARD] = i_cardbus_card;
        state_w[`BIT_16_CARD] = i_16bit_card;
        state_w[`BIT_POWER] = i_status.socket_powered_state;
        state_w[`BIT_DET2] = i_status.detect2_state;
        state_w[`BIT_DET1] = i_status.detect1_state;
        state_w[`BIT_CSTS] = i_status.card_status_state;
        enable_d = enable_q;
        control_d = control_q;
        pm_d = pm_q;
        ack_d = hit;
        rdata_d = `RST_WORD;
        if (wr_hit) begin
            if (ofs == `OFS_ENABLE && i_mem_req.be[0]) begin
                enable_d = i_mem_req.wdata[`EVT_W-1:0];
            end else if (ofs == `OFS_CONTROL) begin
                control_d = merge_be(control_q, i_mem_req.wdata,
                                     i_mem_req.be);
            end else if (ofs == `OFS_PM) begin
                pm_d = merge_be(pm_q, i_mem_req.wdata,
                                i_mem_req.be);
            end
        end
        if (rd_hit) begin
            if (ofs == `OFS_FLAGS) begin
                rdata_d = {28'h0, flags_q};
            end else if (ofs == `OFS_ENABLE) begin
                rdata_d = {28'h0, enable_q};
            end else if (ofs == `OFS_STATE) begin
                rdata_d = state_w;
            end else if (ofs == `OFS_CONTROL) begin
                rdata_d = control_q;
            end else if (rsvd_ofs) begin
                rdata_d = `RST_WORD;
            end else if (ofs == `OFS_PM) begin
                rdata_d = pm_q;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            flags_q      <= `RST_EVT;
            enable_q     <= `RST_EVT;
            control_q    <= `RST_WORD;
            pm_q         <= `RST_WORD;
            rdata_q      <= `RST_WORD;
            ack_q        <= 1'b0;
            prev_q       <= '0;
            prev_valid_q <= 1'b0;
            card_rst_q   <= 1'b0;
        end else begin
            flags_q      <= flags_d;
            enable_q     <= enable_d;
            control_q    <= control_d;
            pm_q         <= pm_d;
            rdata_q      <= rdata_d;
            ack_q        <= ack_d;
            prev_q       <= prev_d;
            prev_valid_q <= prev_valid_d;
            card_rst_q   <= card_rst_d;
        end
    end

    // leftover flags fire at once when enabled; software clears first
    assign o_status_change_interrupt =
        |(flags_q & eff_enable(enable_q));
    assign o_mem_rdata = rdata_q;
    assign o_mem_ack = ack_q;
    assign o_cfg_rdata = cfg_rdata_q;
    assign o_cfg_ack = cfg_ack_q;

    a_w1c_clear: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        clear_w[`BIT_DET1] && !set_w[`BIT_DET1]
        |=> !flags_q[`BIT_DET1]
            ##1 (flags_q[`BIT_DET1] == $past(set_w[`BIT_DET1])))
        else $error("write-one did not clear flag");

    a_inject_sets: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        wr_hit && ofs == `OFS_INJECT && i_mem_req.be[0]
        && i_mem_req.wdata[`BIT_POWER]
        |=> flags_q[`BIT_POWER])
        else $error("inject did not set flag");

    a_power_change: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        prev_valid_q && $changed(i_status.socket_powered_state)
        |=> flags_q[`BIT_POWER])
        else $error("power change not flagged");

    a_cb_rise_only: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        i_cardbus_card && $fell(i_status.card_status_state)
        && !flags_q[`BIT_CSTS] && !inject_w[`BIT_CSTS]
        && !exit_w[`BIT_CSTS]
        |=> !flags_q[`BIT_CSTS])
        else $error("cardbus falling edge flagged");

    a_16bit_edges: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        !i_cardbus_card && prev_valid_q
        && $changed(i_status.card_status_state)
        |=> flags_q[`BIT_CSTS])
        else $error("16-bit status edge not flagged");

    a_flags_rsvd: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        rd_hit && ofs == `OFS_FLAGS
        |=> o_mem_ack && o_mem_rdata[31:`EVT_W] == '0)
        else $error("event reserved bits not zero");

    a_enable_rsvd: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        rd_hit && ofs == `OFS_ENABLE
        |=> o_mem_ack && o_mem_rdata[31:`EVT_W] == '0)
        else $error("mask reserved bits not zero");

    a_det_half_mask: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        enable_q[`BIT_DET2:`BIT_DET1] != `DET_ON
        && !enable_q[`BIT_POWER] && !enable_q[`BIT_CSTS]
        |-> !o_status_change_interrupt)
        else $error("interrupt with detect mask not 11");

    a_irq_raise: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        $rose(flags_q[`BIT_POWER]) && enable_q[`BIT_POWER]
        |-> o_status_change_interrupt)
        else $error("enabled event gave no interrupt");

    a_rsvd_window: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        rd_hit && rsvd_ofs |=> o_mem_ack && o_mem_rdata == '0)
        else $error("reserved offset read nonzero");

    a_reset_exit: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        card_rst_q && !i_card_reset && i_status.detect1_state
        |=> flags_q[`BIT_DET1])
        else $error("reset exit did not re-flag detect");

endmodule : socket_status_event_mask
